// ---- pkg/arb_pkg.sv ----
package arb_pkg;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [31:0] internal_dma_ch1_count_addr = 32'h0182_0110;
	localparam logic [31:0] cpu_arbitration_priority_addr = 32'h0184_1000;
	localparam logic [31:0] master_priority_1_addr = 32'h01c1_4114;
	localparam logic [31:0] master_priority_2_addr = 32'h01c1_4118;
	localparam logic [31:0] max_wait_threshold_addr = 32'h0184_1004;
	localparam logic [31:0] arb_status_addr = 32'h0184_1008;
	// ****************************************
	// field layout and reset values
	// ****************************************
	localparam int pri_w = 3;
	localparam int cpu_pri_lsb = 16;
	localparam int engine_pri_lsb = 29;
	localparam int engine_size_w = 16;
	localparam int mst1_pri_lsb = 0;
	localparam int mst2_pri_lsb = 0;
	localparam int wait_w = 8;
	localparam logic [pri_w-1:0] cmd_pri = 3'h7;
	localparam logic [31:0] cpu_arb_reset = 32'h0000_0000;
	localparam logic [31:0] engine_cnt_reset = 32'h0000_0000;
	localparam logic [31:0] mst_pri_reset = 32'h0000_0000;
	localparam logic [wait_w-1:0] max_wait_reset = 8'h10;
	// requester indices
	localparam int req_n = 3;
	localparam int rq_cpu = 0;
	localparam int rq_engine = 1;
	localparam int rq_port = 2;
	typedef struct packed {
		logic [req_n-1:0] req;
		logic [req_n-1:0] gnt;
	} arb_port_s;
	typedef enum logic [1:0] {grant_none, grant_cpu, grant_dma} last_class_e;
endpackage

// ---- verilog/l2_ram_bandwidth_arbiter.sv ----
`timescale 1ns/100ps
// Functional notes
// - grants go by programmed priority combined with per-requester wait counters.
// - a pending request held off by a stronger one counts one per cycle.
// - a counter at the max-wait threshold forces a grant; starved requesters go engine first, then slave port, then cpu.
// - equal cpu and dma priorities share the ram evenly by alternating.
// - the old defect of always favouring the cpu on a tie is not reproduced.
// - internal command traffic at level 7 never stalls slave-port dma, even with the cpu at 7.
// - every non-cpu requester belongs to the dma class.
// - the cpu priority comes from the cpu arbitration register.
// - the internal dma priority sits above the buffer size in the channel-1 count register.
// - slave-port requests carry the priority of their system master from the master priority registers.
// - equal internal dma and slave-port priorities alternate at no cost; if the cpu ties too, the engine takes every dma turn.
module l2_ram_bandwidth_arbiter
	import arb_pkg::*;
#(
	parameter int wait_bits = wait_w
)(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmd_req,
	input wire logic [req_n-1:0] req,
	input wire logic port_master_sel,
	output logic [req_n-1:0] gnt,
	output logic cmd_gnt
);
	// ****************************************
	// register file
	// ****************************************
	logic [31:0] cpu_arb_q;
	logic [31:0] cpu_arb_d;
	logic [31:0] engine_cnt_q;
	logic [31:0] engine_cnt_d;
	logic [31:0] mst1_q;
	logic [31:0] mst1_d;
	logic [31:0] mst2_q;
	logic [31:0] mst2_d;
	logic [wait_bits-1:0] max_wait_q, max_wait_d;
	logic [31:0] prdata_d;
	logic pready_d, pslverr_d, hit;
	logic [req_n-1:0] gnt_q, gnt_d;
	logic cmd_gnt_q, cmd_gnt_d;
	logic [wait_bits-1:0] cnt_q [req_n];
	logic [wait_bits-1:0] cnt_d [req_n];
	last_class_e last_q, last_d;
	// access phase only once: the !pready term stops a second write in the answer cycle
	wire wr_en = psel && penable && pwrite && !pready;
	wire rd_en = psel && penable && !pwrite && !pready;

	// apb decode; one wait state so pready comes from a flop
	always_comb
	begin
		cpu_arb_d = cpu_arb_q;
		engine_cnt_d = engine_cnt_q;
		mst1_d = mst1_q;
		mst2_d = mst2_q;
		max_wait_d = max_wait_q;
		prdata_d = 32'h0000_0000;
		hit = 1'b1;
		pready_d = psel && penable && !pready;
		case (paddr)
			cpu_arbitration_priority_addr:
			begin
				if (wr_en) cpu_arb_d = pwdata;
				prdata_d = cpu_arb_q;
			end
			internal_dma_ch1_count_addr:
			begin
				// priority and buffer size arrive in one write
				if (wr_en) engine_cnt_d = pwdata;
				prdata_d = engine_cnt_q;
			end
			master_priority_1_addr:
			begin
				if (wr_en) mst1_d = pwdata;
				prdata_d = mst1_q;
			end
			master_priority_2_addr:
			begin
				if (wr_en) mst2_d = pwdata;
				prdata_d = mst2_q;
			end
			max_wait_threshold_addr:
			begin
				if (wr_en) max_wait_d = pwdata[wait_bits-1:0];
				prdata_d = {{(32-wait_bits){1'b0}}, max_wait_q};
			end
			arb_status_addr:
				// port counter on top, grants at [6:4], class at [2:1], command grant at [0]
				prdata_d = {cnt_q[rq_port], {(25-wait_bits){1'b0}}, gnt_q, 1'b0, last_q, cmd_gnt_q};
			default:
				hit = 1'b0;
		endcase
		pslverr_d = pready_d && !hit;
		if (!rd_en) prdata_d = 32'h0000_0000;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			cpu_arb_q <= cpu_arb_reset;
			engine_cnt_q <= engine_cnt_reset;
			mst1_q <= mst_pri_reset;
			mst2_q <= mst_pri_reset;
			max_wait_q <= wait_bits'(max_wait_reset);
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			cpu_arb_q <= cpu_arb_d;
			engine_cnt_q <= engine_cnt_d;
			mst1_q <= mst1_d;
			mst2_q <= mst2_d;
			max_wait_q <= max_wait_d;
			prdata <= prdata_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
		end
	end

	// ****************************************
	// arbitration
	// ****************************************
	logic [pri_w-1:0] pri [req_n];
	logic [req_n-1:0] starved;
	logic [pri_w:0] best;
	logic [req_n-1:0] top;
	logic dma_top;
	// priority pick, starvation override and the tie rules in one place
	always_comb
	begin
		// level 0 is the strongest
		pri[rq_cpu] = cpu_arb_q[cpu_pri_lsb +: pri_w];
		pri[rq_engine] = engine_cnt_q[engine_pri_lsb +: pri_w];
		pri[rq_port] = port_master_sel ? mst2_q[mst2_pri_lsb +: pri_w] : mst1_q[mst1_pri_lsb +: pri_w];
		best = 4'h8;
		top = '0;
		gnt_d = '0;
		cmd_gnt_d = 1'b0;
		last_d = last_q;
		for (int i = 0; i < req_n; i++)
		begin
			starved[i] = req[i] && (cnt_q[i] >= max_wait_q);
			if (req[i] && {1'b0, pri[i]} < best) best = {1'b0, pri[i]};
		end
		for (int i = 0; i < req_n; i++)
			top[i] = req[i] && ({1'b0, pri[i]} == best);
		// internal_dma_engine and slave_dma_port in one class: round by last grant, no penalty; in a tie with the cpu the engine takes the dma turn
		dma_top = top[rq_engine] || top[rq_port];
		if (|starved)
		begin
			// a starved requester wins over anything; dma class first, cpu last
			if (starved[rq_engine]) gnt_d[rq_engine] = 1'b1;
			else if (starved[rq_port]) gnt_d[rq_port] = 1'b1;
			else gnt_d[rq_cpu] = 1'b1;
		end
		else if (top[rq_cpu] && dma_top)
		begin
			// tie between classes alternates instead of always favouring the cpu
			if (last_q == grant_cpu) gnt_d[top[rq_engine] ? rq_engine : rq_port] = 1'b1;
			else gnt_d[rq_cpu] = 1'b1;
		end
		else if (top[rq_cpu]) gnt_d[rq_cpu] = 1'b1;
		else if (top[rq_engine] && top[rq_port]) gnt_d[gnt_q[rq_engine] ? rq_port : rq_engine] = 1'b1;
		else if (top[rq_engine]) gnt_d[rq_engine] = 1'b1;
		else if (top[rq_port]) gnt_d[rq_port] = 1'b1;
		// command traffic at level 7 takes only idle slots so it never blocks dma
		if (gnt_d == '0 && cmd_req) cmd_gnt_d = 1'b1;
		if (gnt_d[rq_cpu]) last_d = grant_cpu;
		else if (gnt_d != '0) last_d = grant_dma;
	end

	// ****************************************
	// contention counters
	// ****************************************
	// counters saturate rather than wrap, so a long stall cannot look like a fresh request
	always_comb
	begin
		for (int i = 0; i < req_n; i++)
		begin
			if (!req[i] || gnt_d[i]) cnt_d[i] = '0;
			else if (cnt_q[i] != '1) cnt_d[i] = cnt_q[i] + 1'b1;
			else cnt_d[i] = cnt_q[i];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < req_n; i++) cnt_q[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < req_n; i++) cnt_q[i] <= cnt_d[i];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			gnt_q <= '0;
			cmd_gnt_q <= 1'b0;
			last_q <= grant_none;
		end
		else
		begin
			gnt_q <= gnt_d;
			cmd_gnt_q <= cmd_gnt_d;
			last_q <= last_d;
		end
	end
	assign gnt = gnt_q;
	assign cmd_gnt = cmd_gnt_q;

	// ****************************************
	// checks
	// ****************************************
	// grant shape
	a_grant_onehot: assert property (@(posedge clk) disable iff (!reset_n) $onehot0({gnt_q, cmd_gnt_q}))
		else $error("more than one grant");
	a_grant_needs_req: assert property (@(posedge clk) disable iff (!reset_n)
		(gnt_q & ~$past(req)) == '0)
		else $error("grant without request");
	a_strongest_wins: assert property (@(posedge clk) disable iff (!reset_n)
		(~|starved && |req) |=> |(gnt_q & $past(top)))
		else $error("grant missed the strongest level");

	// starvation relief
	a_starve_grant: assert property (@(posedge clk) disable iff (!reset_n)
		(req[rq_engine] && cnt_q[rq_engine] >= max_wait_q) |=> gnt_q[rq_engine])
		else $error("starved dma not granted");
	a_port_starve: assert property (@(posedge clk) disable iff (!reset_n)
		(starved[rq_port] && !starved[rq_engine]) |=> gnt_q[rq_port])
		else $error("starved port not granted");
	a_cpu_starve: assert property (@(posedge clk) disable iff (!reset_n)
		(starved[rq_cpu] && !starved[rq_engine] && !starved[rq_port]) |=> gnt_q[rq_cpu])
		else $error("starved cpu not granted");

	// counters
	a_count_step: assert property (@(posedge clk) disable iff (!reset_n)
		(req[rq_port] && !gnt_d[rq_port] && cnt_q[rq_port] != '1) |=> cnt_q[rq_port] == $past(cnt_q[rq_port]) + 1'b1)
		else $error("contention count did not step");
	a_count_sat: assert property (@(posedge clk) disable iff (!reset_n)
		(req[rq_engine] && !gnt_d[rq_engine] && cnt_q[rq_engine] == '1) |=> cnt_q[rq_engine] == '1)
		else $error("contention count wrapped");
	a_port_clear: assert property (@(posedge clk) disable iff (!reset_n)
		!req[rq_port] |=> cnt_q[rq_port] == '0)
		else $error("idle counter not clear");
	a_count_clear: assert property (@(posedge clk) disable iff (!reset_n)
		(!req[rq_cpu] || gnt_d[rq_cpu]) |=> cnt_q[rq_cpu] == '0)
		else $error("counter not cleared");

	// ties and command slots
	a_tie_alternate: assert property (@(posedge clk) disable iff (!reset_n)
		(gnt_q[rq_cpu] && req[rq_cpu] && req[rq_engine] && pri[rq_cpu] == pri[rq_engine] && ~|starved
		&& pri[rq_engine] <= pri[rq_port]) |=> !gnt_q[rq_cpu])
		else $error("cpu kept winning a tie");
	a_last_class: assert property (@(posedge clk) disable iff (!reset_n)
		gnt_q[rq_cpu] |-> last_q == grant_cpu)
		else $error("last class lost the cpu grant");
	a_cmd_idle_only: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_gnt_q |-> $past(req == '0 || gnt_d == '0))
		else $error("command slot stole a grant");
	a_cmd_needs_req: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_gnt_q |-> $past(cmd_req))
		else $error("command grant without request");
	a_dma_even: assert property (@(posedge clk) disable iff (!reset_n)
		(gnt_q[rq_engine] && req[rq_engine] && req[rq_port] && !req[rq_cpu] && pri[rq_engine] == pri[rq_port]
		&& ~|starved) |=> gnt_q[rq_port])
		else $error("dma requesters did not share");

	// register bus
	a_apb_ready: assert property (@(posedge clk) disable iff (!reset_n)
		(psel && !penable) ##1 (psel && penable) |=> pready)
		else $error("apb answer late");
	a_ready_pulse: assert property (@(posedge clk) disable iff (!reset_n)
		pready |=> !pready)
		else $error("ready held too long");
	a_err_with_ready: assert property (@(posedge clk) disable iff (!reset_n)
		pslverr |-> pready)
		else $error("error without ready");
	a_rdata_quiet: assert property (@(posedge clk) disable iff (!reset_n)
		!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside answer");

	// main scenarios
	c_tie: cover property (@(posedge clk) disable iff (!reset_n) gnt_q[rq_cpu] ##1 gnt_q[rq_engine]);
	c_starve: cover property (@(posedge clk) disable iff (!reset_n) starved[rq_port] && req[rq_cpu]);
	c_cmd: cover property (@(posedge clk) disable iff (!reset_n) cmd_gnt_q);
	c_dma_tie: cover property (@(posedge clk) disable iff (!reset_n) gnt_q[rq_engine] ##1 gnt_q[rq_port]);
	c_bad_addr: cover property (@(posedge clk) disable iff (!reset_n) pslverr);
endmodule // l2_ram_bandwidth_arbiter

// ---- sim/requester_model.sv ----
`timescale 1ns/100ps
// ****************
// cpu, internal dma and system masters
// ****************
module requester_model
	import arb_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [req_n-1:0] want,
	input wire logic clear,
	input wire logic [req_n-1:0] gnt,
	output logic [req_n-1:0] req,
	output logic [7:0] hits [req_n]
);
	// bit 0 is the cpu, every other bit is a dma-class master
	assign req = reset_n ? want : '0;
	// grant tally per requester, cleared between windows
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < req_n; i++)
			hits[i] <= (clear || !reset_n) ? 8'h00 : hits[i] + {7'h00, gnt[i]};
	end
endmodule // requester_model

// ---- sim/l2_ram_bandwidth_arbiter_bench.sv ----
`timescale 1ns/100ps
module l2_ram_bandwidth_arbiter_bench
	import arb_pkg::*;
;
	logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
	logic cmd_req = 0, port_master_sel = 0, cmd_gnt, clr = 0;
	logic [req_n-1:0] want = 0, req, gnt;
	logic [7:0] hits [req_n];
	int fail_count = 0, total_checks = 0, cyc = 0;
	always #2 clk = ~clk;
	l2_ram_bandwidth_arbiter uut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmd_req(cmd_req), .req(req), .port_master_sel(port_master_sel),
		.gnt(gnt), .cmd_gnt(cmd_gnt));
	requester_model far (.clk(clk), .reset_n(reset_n), .want(want), .clear(clr), .gnt(gnt),
		.req(req), .hits(hits));
	// ****************
	// helpers
	// ****************
	task automatic end_sim();
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e)
		begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	// one apb transfer; waits on pready rather than assuming the wait state
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = pslverr ? 32'hffff_ffff : prdata;
		psel <= 0;
		penable <= 0;
	endtask
	// hold a request pattern for a fixed window and tally grants
	task automatic run(input logic [req_n-1:0] w, input int n);
		@(posedge clk);
		want <= w;
		clr <= 1;
		@(posedge clk);
		clr <= 0;
		repeat (n) @(posedge clk);
		want <= 0;
		repeat (3) @(posedge clk);
	endtask
	// a hang is cut short here and counted
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail_count++;
			end_sim();
		end
	end
	// at most one slot per cycle
	always @(posedge clk)
		if (reset_n && !$onehot0(gnt))
			chk("onehot", 1, 0);
	// ****************
	// main sequence
	// ****************
	initial
	begin
		repeat (4) @(posedge clk);
		reset_n <= 1;
		apb(0, cpu_arbitration_priority_addr, 0);
		chk("cpu_rst", cpu_arb_reset, rd);
		apb(0, max_wait_threshold_addr, 0);
		chk("wait_rst", 32'h10, rd);
		apb(0, 32'h0184_1010, 0);
		chk("unmapped", 32'hffff_ffff, rd);
		apb(1, max_wait_threshold_addr, 32'h4);
		// all priorities still equal after reset
		run(3'b011, 20);
		chk("tie", 1, hits[0] >= 9 && hits[1] >= 9);
		// cpu stronger; software keeps the levels apart
		apb(1, cpu_arbitration_priority_addr, 32'h1 << cpu_pri_lsb);
		apb(1, internal_dma_ch1_count_addr, (32'h5 << engine_pri_lsb) | 32'h40);
		apb(0, internal_dma_ch1_count_addr, 0);
		chk("internal_dma_engine_reg", 32'ha000_0040, rd);
		run(3'b011, 30);
		chk("starve", 1, hits[1] >= 1 && hits[1] < hits[0]);
		apb(1, master_priority_1_addr, 32'h5);
		run(3'b110, 20);
		chk("dma_tie", 1, hits[1] >= 9 && hits[2] >= 9);
		apb(1, master_priority_2_addr, 32'h0);
		port_master_sel <= 1;
		run(3'b101, 20);
		chk("mst2", 1, hits[2] > hits[0]);
		apb(1, cpu_arbitration_priority_addr, 32'h7 << cpu_pri_lsb);
		apb(1, master_priority_1_addr, 32'h7);
		port_master_sel <= 0;
		cmd_req <= 1;
		run(3'b101, 20);
		chk("lvl7", 1, hits[2] >= 9);
		chk("cmd_idle", 1, cmd_gnt);
		end_sim();
	end
endmodule // l2_ram_bandwidth_arbiter_bench
